// file: core/pspcr_regs.sv
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
module pspcr_regs
  import pspcr_pkg::*;
#(
  parameter logic [23:0] MODEL_CODE = 24'hA5_5A_01
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic [7:0] page_number,
  output logic page_reserved,
  output pspcr_panel_t panel_mode,
  output logic [7:0] vertical_front_porch_lines,
  output logic [7:0] vertical_back_porch_lines,
  output logic porch_setting_error
);
  // MODEL_CODE default is arbitrary

  pspcr_unlock_t unlock_reg, unlock_next;
  logic [7:0] page_reg, page_next;
  logic [7:0] mode_reg, mode_next;
  logic [7:0] vfp_reg, vfp_next;
  logic [7:0] vbp_reg, vbp_next;
  logic [7:0] rd_reg, rd_next;
  logic on_page1;
  logic sel_page;

  assign on_page1 = (page_reg == PSPCR_PAGE_ONE);
  assign sel_page = (addr == PSPCR_OFF_PAGE_SEL);

  // Unlock sequence; any other write to the select address restarts it
  always_comb begin
    unlock_next = unlock_reg;
    page_next = page_reg;
    if (wr_en && sel_page) begin
      case (unlock_reg)
        PSPCR_UNLOCK_IDLE: begin
          unlock_next = (wr_data == PSPCR_KEY_FIRST) ? PSPCR_UNLOCK_KEY1 : PSPCR_UNLOCK_IDLE;
        end
        PSPCR_UNLOCK_KEY1: begin
          unlock_next = (wr_data == PSPCR_KEY_SECOND) ? PSPCR_UNLOCK_KEY2 : PSPCR_UNLOCK_IDLE;
        end
        PSPCR_UNLOCK_KEY2: begin
          page_next = wr_data;
          unlock_next = PSPCR_UNLOCK_IDLE;
        end
        default: begin
          unlock_next = PSPCR_UNLOCK_IDLE;
        end
      endcase
    end
  end

  // Page registers only write on page 1
  always_comb begin
    mode_next = mode_reg;
    vfp_next = vfp_reg;
    vbp_next = vbp_reg;
    if (wr_en && on_page1) begin
      case (addr)
        PSPCR_OFF_PANEL_MODE: begin
          mode_next = wr_data & PSPCR_MODE_MASK;
        end
        PSPCR_OFF_VFP: begin
          vfp_next = wr_data;
        end
        PSPCR_OFF_VBP: begin
          vbp_next = wr_data;
        end
        default: begin
          mode_next = mode_reg;
        end
      endcase
    end
  end

  // Unmapped reads return zero
  always_comb begin
    rd_next = 8'h00;
    if (rd_en) begin
      if (addr == PSPCR_OFF_STATUS) begin
        rd_next = page_reg;
      end else if (on_page1) begin
        case (addr)
          PSPCR_OFF_MODEL_HIGH: rd_next = MODEL_CODE[23:16];
          PSPCR_OFF_MODEL_MID: rd_next = MODEL_CODE[15:8];
          PSPCR_OFF_MODEL_LOW: rd_next = MODEL_CODE[7:0];
          PSPCR_OFF_PANEL_MODE: rd_next = mode_reg;
          PSPCR_OFF_VFP: rd_next = vfp_reg;
          PSPCR_OFF_VBP: rd_next = vbp_reg;
          default: rd_next = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      unlock_reg <= PSPCR_UNLOCK_IDLE;
      page_reg <= PSPCR_RST_PAGE;
      mode_reg <= PSPCR_RST_PANEL_MODE;
      vfp_reg <= PSPCR_RST_VFP;
      vbp_reg <= PSPCR_RST_VBP;
      rd_reg <= 8'h00;
    end else begin
      unlock_reg <= unlock_next;
      page_reg <= page_next;
      mode_reg <= mode_next;
      vfp_reg <= vfp_next;
      vbp_reg <= vbp_next;
      rd_reg <= rd_next;
    end
  end

  assign rd_data = rd_reg;
  assign page_number = page_reg;
  assign page_reserved = (page_reg > PSPCR_PAGE_MAX);
  assign panel_mode.color_expansion_format = mode_reg[PSPCR_POS_EXP +: 2];
  assign panel_mode.color_filter_order = mode_reg[PSPCR_POS_ORDER];
  assign panel_mode.panel_polarity_select = mode_reg[PSPCR_POS_POL];
  assign panel_mode.source_scan_reverse = mode_reg[PSPCR_POS_SRC];
  assign panel_mode.gate_scan_reverse = mode_reg[PSPCR_POS_GATE];
  assign vertical_front_porch_lines = vfp_reg;
  assign vertical_back_porch_lines = vbp_reg;
  // Flag only; prohibited values are stored as written
  assign porch_setting_error = (vfp_reg < PSPCR_PORCH_MIN) || (vbp_reg < PSPCR_PORCH_MIN);
endmodule // pspcr_regs

// file: core/pspcr_pkg.sv
package pspcr_pkg;
  localparam logic [7:0] PSPCR_OFF_MODEL_HIGH = 8'h00;
  localparam logic [7:0] PSPCR_OFF_MODEL_MID = 8'h01;
  localparam logic [7:0] PSPCR_OFF_MODEL_LOW = 8'h02;
  localparam logic [7:0] PSPCR_OFF_PANEL_MODE = 8'h22;
  localparam logic [7:0] PSPCR_OFF_VFP = 8'h25;
  localparam logic [7:0] PSPCR_OFF_VBP = 8'h26;
  localparam logic [7:0] PSPCR_OFF_PAGE_SEL = 8'hFF;
  localparam logic [7:0] PSPCR_OFF_STATUS = 8'hFE;
  localparam logic [7:0] PSPCR_KEY_FIRST = 8'h98;
  localparam logic [7:0] PSPCR_KEY_SECOND = 8'h81;
  localparam logic [7:0] PSPCR_PAGE_MAX = 8'h0A;
  localparam logic [7:0] PSPCR_PAGE_ONE = 8'h01;
  localparam logic [7:0] PSPCR_RST_PAGE = 8'h00;
  localparam logic [7:0] PSPCR_RST_PANEL_MODE = 8'h30;
  localparam logic [7:0] PSPCR_RST_VFP = 8'h14;
  localparam logic [7:0] PSPCR_RST_VBP = 8'h14;
  localparam int PSPCR_POS_EXP = 4;
  localparam int PSPCR_POS_ORDER = 3;
  localparam int PSPCR_POS_POL = 2;
  localparam int PSPCR_POS_SRC = 1;
  localparam int PSPCR_POS_GATE = 0;
  localparam logic [7:0] PSPCR_MODE_MASK = 8'h3F;
  localparam logic [7:0] PSPCR_PORCH_MIN = 8'h02;

  typedef enum logic [1:0] {
    PSPCR_UNLOCK_IDLE = 2'b00,
    PSPCR_UNLOCK_KEY1 = 2'b01,
    PSPCR_UNLOCK_KEY2 = 2'b10
  } pspcr_unlock_t;

  typedef struct packed {
    logic [1:0] color_expansion_format;
    logic color_filter_order;
    logic panel_polarity_select;
    logic source_scan_reverse;
    logic gate_scan_reverse;
  } pspcr_panel_t;
endpackage

// file: verification/pspcr_chk.sv
`timescale 1ns/10ps
module pspcr_chk
  import pspcr_pkg::*;
(input wire logic clock, rst, wr_en, rd_en, page_reserved, porch_setting_error,
  input wire logic [7:0] addr, wr_data, rd_data, page_number,
  input wire logic [7:0] vertical_front_porch_lines, vertical_back_porch_lines,
  input wire pspcr_panel_t panel_mode);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic p1 = page_number == 8'h01;
  wire logic wf = wr_en && addr == 8'hFF;
  wire logic wm = wr_en && addr == 8'h22;
  wire logic rm = rd_en && addr == 8'h22;
  sequence s_key; wf && wr_data == 8'h98 ##1 wf && wr_data == 8'h81; endsequence
  property p_page; s_key ##1 wf |=> page_number == $past(wr_data); endproperty
  a_page: assert property (p_page) else $error("page");
  property p_keep; !wf |=> $stable(page_number); endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_resv; page_reserved == (page_number > 8'h0A); endproperty
  a_resv: assert property (p_resv) else $error("resv");
  property p_mode; wm && p1 |=> panel_mode == 6'($past(wr_data)); endproperty
  a_mode: assert property (p_mode) else $error("mode");
  property p_lock; wm && !p1 |=> $stable(panel_mode); endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_rdm; rm && p1 |=> rd_data == {2'b00, $past(panel_mode)}; endproperty
  a_rdm: assert property (p_rdm) else $error("rdm");
  property p_rdoff; rm && !p1 |=> rd_data == 8'h00; endproperty
  a_rdoff: assert property (p_rdoff) else $error("rdoff");
  property p_idle; !$past(rd_en) |-> rd_data == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_vfp;
    wr_en && addr == 8'h25 && p1 |=> vertical_front_porch_lines == $past(wr_data);
  endproperty
  a_vfp: assert property (p_vfp) else $error("vfp");
  property p_vbp;
    wr_en && addr == 8'h26 && p1 |=> vertical_back_porch_lines == $past(wr_data);
  endproperty
  a_vbp: assert property (p_vbp) else $error("vbp");
  property p_perr;
    porch_setting_error == (vertical_front_porch_lines < 8'h02 || vertical_back_porch_lines < 8'h02);
  endproperty
  a_perr: assert property (p_perr) else $error("perr");
endmodule // pspcr_chk
bind pspcr_regs pspcr_chk i_chk (.*);

// file: verification/pspcr_host.sv
`timescale 1ns/10ps
module pspcr_host (input wire logic clock,
  output logic [7:0] addr = 8'h00, wr_data = 8'h00, output logic wr_en = 1'b0, rd_en = 1'b0);
  task automatic op(input logic w, r, input logic [7:0] a, d);
    @(posedge clock);
    {wr_en, rd_en, addr, wr_data} <= {w, r, a, d};
  endtask
  task automatic page(input logic [7:0] p);
    for (int i = 0; i < 4; i++) op(i < 3, 1'b0, 8'hFF, i == 0 ? 8'h98 : i == 1 ? 8'h81 : p);
  endtask
endmodule // pspcr_host

// file: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clock = 1'b0, rst = 1'b1;
  logic [7:0] addr, wr_data, rd_data, page_number;
  logic [7:0] vertical_front_porch_lines, vertical_back_porch_lines;
  logic wr_en, rd_en, page_reserved, porch_setting_error;
  pspcr_pkg::pspcr_panel_t panel_mode;
  int fail_count = 0, n_tests = 0;
  initial forever #4 clock = ~clock;
  pspcr_host i_host (.*);
  pspcr_regs #(.MODEL_CODE(24'h123456)) i_dut (.*); // Arbitrary code
  task automatic chk(input string n, input logic [7:0] e, g);
    n_tests++;
    fail_count += int'(g !== e);
    if (g !== e) $display("[ERR] %s exp %h got %h", n, e, g);
  endtask
  task automatic rd(input logic [7:0] a, e);
    i_host.op(1'b0, 1'b1, a, 8'h00);
    i_host.op(1'b0, 1'b0, a, 8'h00);
    #1 chk("rd_data", e, rd_data);
  endtask
  task automatic xfer(input logic [7:0] a, d, e);
    i_host.op(1'b1, 1'b0, a, d);
    rd(a, e);
  endtask
  task automatic t_page();
    #1 chk("panel_mode", 8'h30, 8'(panel_mode));
    i_host.page(8'h0A);
    #1 chk("page_reserved", 8'h00, 8'(page_reserved));
    i_host.page(8'h0B);
    #1 chk("page_reserved", 8'h01, 8'(page_reserved));
    i_host.page(8'h01);
    for (int i = 0; i < 3; i++) xfer(8'(i), 8'hFF, 8'h12 + 8'h22 * 8'(i));
  endtask
  task automatic t_cfg();
    for (int i = 0; i < 6; i++) begin
      xfer(8'h22, 8'hC0 | 8'h01 << i, 8'h01 << i);
      chk("panel_mode", 8'h01 << i, 8'(panel_mode));
    end
    xfer(8'h25, 8'h02, 8'h02);
    xfer(8'h26, 8'hFF, 8'hFF);
    chk("vfp", 8'h02, vertical_front_porch_lines);
    chk("vbp", 8'hFF, vertical_back_porch_lines);
    chk("porch_setting_error", 8'h00, 8'(porch_setting_error));
    rd(8'hFE, 8'h01);
    i_host.page(8'h00);
    xfer(8'h22, 8'h00, 8'h00);
    chk("page_number", 8'h00, page_number);
    i_host.page(8'h01);
    rd(8'h22, 8'h20);
  endtask
  task automatic t_rst();
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1 chk("panel_mode", 8'h30, 8'(panel_mode));
    chk("vfp", 8'h14, vertical_front_porch_lines);
    chk("vbp", 8'h14, vertical_back_porch_lines);
    chk("page_number", 8'h00, page_number);
    i_host.page(8'h01);
    rd(8'h22, 8'h30);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_page();
    t_cfg();
    t_rst();
    summarize();
  end
endmodule // tb_top
